// [hw/tss_cfg.svh]
`ifndef TSS_CFG_SVH
`define TSS_CFG_SVH

// Master clock rate and the derived cycles per time unit
`define TSS_CLK_HZ 50000000
`define TSS_CYC_PER_MS (`TSS_CLK_HZ / 1000)
`define TSS_CYC_PER_US (`TSS_CLK_HZ / 1000000)

// Common step delay of the default timing option, in ms
`define TSS_DELAY_MS 10
// Extra time added to the first up and first down step, in us
`define TSS_EXTRA_US 400
// Settle pause after an interrupted sequence, in ms
`define TSS_SETTLE_MS 120

// Cycle counts derived from the times above
`define TSS_DELAY_CYC (`TSS_DELAY_MS * `TSS_CYC_PER_MS)
`define TSS_EXTRA_CYC (`TSS_EXTRA_US * `TSS_CYC_PER_US)
`define TSS_SETTLE_CYC (`TSS_SETTLE_MS * `TSS_CYC_PER_MS)

// Timer counter width and default falling order (sequence number)
`define TSS_CNT_W 32
`define TSS_DOWN_SEQ 1

// Reset value of the pull-low drives: all three flags held low
`define TSS_LOW_RST 3'h7

`endif

// [hw/tss_pkg.sv]
`include "tss_cfg.svh"

package tss_pkg;

	// Sequencer states, one-hot
	typedef enum logic [9:0] {
		TSS_OFF = 10'h001,
		TSS_UP1 = 10'h002,
		TSS_UP2 = 10'h004,
		TSS_UP3 = 10'h008,
		TSS_ON = 10'h010,
		TSS_DN1 = 10'h020,
		TSS_DN2 = 10'h040,
		TSS_DN3 = 10'h080,
		TSS_SETL_U = 10'h100,
		TSS_SETL_D = 10'h200
	} tss_state_t;

	// Request to the shared step timer
	typedef struct packed {
		logic start;
		logic clear;
		logic [`TSS_CNT_W-1:0] len;
	} tss_tmr_req_t;

endpackage

// [hw/tss_timer.sv]
`timescale 1ns/1ps
`include "tss_cfg.svh"

module tss_timer (
	input wire logic clk,
	input wire logic resetn,
	input tss_pkg::tss_tmr_req_t req,
	output logic done,
	output logic busy
);

	logic [`TSS_CNT_W-1:0] cnt_q;
	logic run_q;

	// Start loads len-1 so that done comes exactly len cycles after start
	always_ff @(posedge clk) begin
		if (!resetn) begin
			cnt_q <= '0;
			run_q <= 1'b0;
		end else if (req.start) begin
			cnt_q <= req.len - `TSS_CNT_W'(1);
			run_q <= 1'b1;
		end else if (req.clear || (run_q && cnt_q == '0)) begin
			cnt_q <= '0;
			run_q <= 1'b0;
		end else if (run_q) begin
			cnt_q <= cnt_q - `TSS_CNT_W'(1);
		end
	end

	// Done is a one-cycle pulse on the last counted cycle
	assign done = run_q && cnt_q == '0 && !req.clear;
	assign busy = run_q;

endmodule

// [hw/tss_sequencer.sv]
`timescale 1ns/1ps
`include "tss_cfg.svh"

// Contract
// - Three open-drain flags: pull low or release
// - All flags low until enable first asserted
// - Enable starts timer one; expiry releases first
// - Each release starts next timer for next flag
// - Enable low: timed pull-low of three flags
// - Down delays independent of up delays
// - Early enable drop resets timer, flags low
// - Drop mid power-up restarts timer, finishes up
// - Settle pause after forced power-up completion
// - Rise mid power-down restarts timer, finishes down
// - Settle pause after forced power-down completion
// - Extra delay on first up and down step
// - Delays held within tolerance of nominal
// - First-to-second delay ratio kept near one
// - Second-to-third delay ratio kept near one
// - All timers run from one master clock
// - Standard build uses default flag ordering
// - Default order: rise 1-2-3, fall 3-2-1
// - Falling order selectable among six permutations
// - Timing options share one common step delay
module tss_sequencer #(
	parameter int unsigned UP_FIRST_CYC = `TSS_DELAY_CYC,
	parameter int unsigned UP_SECOND_CYC = `TSS_DELAY_CYC,
	parameter int unsigned UP_THIRD_CYC = `TSS_DELAY_CYC,
	parameter int unsigned DOWN_FIRST_CYC = `TSS_DELAY_CYC,
	parameter int unsigned DOWN_SECOND_CYC = `TSS_DELAY_CYC,
	parameter int unsigned DOWN_THIRD_CYC = `TSS_DELAY_CYC,
	parameter int unsigned EXTRA_CYC = `TSS_EXTRA_CYC,
	parameter int unsigned SETTLE_CYC = `TSS_SETTLE_CYC,
	parameter int unsigned DOWN_SEQ = `TSS_DOWN_SEQ
) (
	input wire logic CLK_SYS,
	input wire logic RESETN,
	input wire logic SEQ_ENABLE,
	output logic RAIL_FLAG_FIRST_O,
	output logic RAIL_FLAG_FIRST_OE,
	output logic RAIL_FLAG_SECOND_O,
	output logic RAIL_FLAG_SECOND_OE,
	output logic RAIL_FLAG_THIRD_O,
	output logic RAIL_FLAG_THIRD_OE
);

	localparam int CW = `TSS_CNT_W;

	// Step lengths; the first steps carry the extra delay
	localparam logic [CW-1:0] LEN_UP1 = CW'(UP_FIRST_CYC + EXTRA_CYC);
	localparam logic [CW-1:0] LEN_UP2 = CW'(UP_SECOND_CYC);
	localparam logic [CW-1:0] LEN_UP3 = CW'(UP_THIRD_CYC);
	localparam logic [CW-1:0] LEN_DN1 = CW'(DOWN_FIRST_CYC + EXTRA_CYC);
	localparam logic [CW-1:0] LEN_DN2 = CW'(DOWN_SECOND_CYC);
	localparam logic [CW-1:0] LEN_DN3 = CW'(DOWN_THIRD_CYC);
	localparam logic [CW-1:0] LEN_SETL = CW'(SETTLE_CYC);

	// Flag index pulled low at each down step, per sequence number
	function automatic logic [1:0] down_idx(input int unsigned seq, input int unsigned step);
		logic [5:0] map;
		map = 6'h06;
		case (seq)
			2: map = 6'h12;
			3: map = 6'h09;
			4: map = 6'h21;
			5: map = 6'h18;
			6: map = 6'h24;
			default: map = 6'h06;
		endcase
		return map[2*step +: 2];
	endfunction

	// Build-time falling order, never changes in operation
	localparam logic [1:0] DN_IDX0 = down_idx(DOWN_SEQ, 0);
	localparam logic [1:0] DN_IDX1 = down_idx(DOWN_SEQ, 1);
	localparam logic [1:0] DN_IDX2 = down_idx(DOWN_SEQ, 2);

	tss_pkg::tss_state_t st_q;
	tss_pkg::tss_state_t st_d;
	tss_pkg::tss_tmr_req_t req;
	logic tmr_done;
	logic tmr_busy;
	logic en_m_q;
	logic en_s_q;
	logic en_p_q;
	logic en_rise;
	logic en_fall;
	logic [2:0] low_q;
	logic [2:0] flag_oe;
	logic [2:0] flag_o;

	// Two-flop synchroniser; the second stage and its delayed copy en_p_q feed the logic
	always_ff @(posedge CLK_SYS) begin
		if (!RESETN) begin
			en_m_q <= 1'b0;
			en_s_q <= 1'b0;
			en_p_q <= 1'b0;
		end else begin
			en_m_q <= SEQ_ENABLE;
			en_s_q <= en_m_q;
			en_p_q <= en_s_q;
		end
	end

	// Edge detection on the settled copy
	assign en_rise = en_s_q && !en_p_q;
	assign en_fall = !en_s_q && en_p_q;

	// One shared timer on the master clock keeps the step ratios fixed
	tss_timer u_timer (
		.clk(CLK_SYS),
		.resetn(RESETN),
		.req(req),
		.done(tmr_done),
		.busy(tmr_busy)
	);

	// Next state and timer requests
	always_comb begin
		st_d = st_q;
		req.start = 1'b0;
		req.clear = 1'b0;
		req.len = '0;
		unique case (st_q)
			tss_pkg::TSS_OFF: begin
				if (en_s_q) begin
					st_d = tss_pkg::TSS_UP1;
					req.start = 1'b1;
					req.len = LEN_UP1;
				end
			end
			tss_pkg::TSS_UP1: begin
				if (en_fall) begin
					st_d = tss_pkg::TSS_OFF;
					req.clear = 1'b1;
				end else if (tmr_done) begin
					st_d = tss_pkg::TSS_UP2;
					req.start = 1'b1;
					req.len = LEN_UP2;
				end
			end
			tss_pkg::TSS_UP2: begin
				if (tmr_done) begin
					st_d = tss_pkg::TSS_UP3;
					req.start = 1'b1;
					req.len = LEN_UP3;
				end else if (en_fall) begin
					req.start = 1'b1;
					req.len = LEN_UP2;
				end
			end
			tss_pkg::TSS_UP3: begin
				if (tmr_done && en_s_q) begin
					st_d = tss_pkg::TSS_ON;
				end else if (tmr_done) begin
					st_d = tss_pkg::TSS_SETL_U;
					req.start = 1'b1;
					req.len = LEN_SETL;
				end else if (en_fall) begin
					req.start = 1'b1;
					req.len = LEN_UP3;
				end
			end
			tss_pkg::TSS_ON: begin
				if (!en_s_q) begin
					st_d = tss_pkg::TSS_DN1;
					req.start = 1'b1;
					req.len = LEN_DN1;
				end
			end
			tss_pkg::TSS_DN1: begin
				if (en_rise) begin
					st_d = tss_pkg::TSS_ON;
					req.clear = 1'b1;
				end else if (tmr_done) begin
					st_d = tss_pkg::TSS_DN2;
					req.start = 1'b1;
					req.len = LEN_DN2;
				end
			end
			tss_pkg::TSS_DN2: begin
				if (tmr_done) begin
					st_d = tss_pkg::TSS_DN3;
					req.start = 1'b1;
					req.len = LEN_DN3;
				end else if (en_rise) begin
					req.start = 1'b1;
					req.len = LEN_DN2;
				end
			end
			tss_pkg::TSS_DN3: begin
				if (tmr_done && !en_s_q) begin
					st_d = tss_pkg::TSS_OFF;
				end else if (tmr_done) begin
					st_d = tss_pkg::TSS_SETL_D;
					req.start = 1'b1;
					req.len = LEN_SETL;
				end else if (en_rise) begin
					req.start = 1'b1;
					req.len = LEN_DN3;
				end
			end
			tss_pkg::TSS_SETL_U: begin
				if (tmr_done && !en_s_q) begin
					st_d = tss_pkg::TSS_DN1;
					req.start = 1'b1;
					req.len = LEN_DN1;
				end else if (tmr_done) begin
					st_d = tss_pkg::TSS_ON;
				end
			end
			tss_pkg::TSS_SETL_D: begin
				if (tmr_done && en_s_q) begin
					st_d = tss_pkg::TSS_UP1;
					req.start = 1'b1;
					req.len = LEN_UP1;
				end else if (tmr_done) begin
					st_d = tss_pkg::TSS_OFF;
				end
			end
			default: begin
				st_d = tss_pkg::TSS_OFF;
				req.clear = 1'b1;
			end
		endcase
	end

	// State register
	always_ff @(posedge CLK_SYS) begin
		if (!RESETN) begin
			st_q <= tss_pkg::TSS_OFF;
		end else begin
			st_q <= st_d;
		end
	end

	// Pull-low drives; rise order is fixed, fall order from the map
	always_ff @(posedge CLK_SYS) begin
		if (!RESETN) begin
			low_q <= `TSS_LOW_RST;
		end else if (tmr_done) begin
			unique case (st_q)
				tss_pkg::TSS_UP1: low_q[0] <= 1'b0;
				tss_pkg::TSS_UP2: low_q[1] <= 1'b0;
				tss_pkg::TSS_UP3: low_q[2] <= 1'b0;
				tss_pkg::TSS_DN1: low_q[DN_IDX0] <= 1'b1;
				tss_pkg::TSS_DN2: low_q[DN_IDX1] <= 1'b1;
				tss_pkg::TSS_DN3: low_q[DN_IDX2] <= 1'b1;
				default: low_q <= low_q;
			endcase
		end
	end

	// Open-drain pins: data is always low, enable means pulling low
	for (genvar i = 0; i < 3; i++) begin : g_flag
		assign flag_o[i] = 1'b0;
		assign flag_oe[i] = low_q[i];
	end

	assign RAIL_FLAG_FIRST_O = flag_o[0];
	assign RAIL_FLAG_FIRST_OE = flag_oe[0];
	assign RAIL_FLAG_SECOND_O = flag_o[1];
	assign RAIL_FLAG_SECOND_OE = flag_oe[1];
	assign RAIL_FLAG_THIRD_O = flag_o[2];
	assign RAIL_FLAG_THIRD_OE = flag_oe[2];

	// Helper for checks: cycles since the last timer start
	logic [CW-1:0] elap_q;
	always_ff @(posedge CLK_SYS) begin
		if (!RESETN) begin
			elap_q <= '0;
		end else if (req.start) begin
			elap_q <= '0;
		end else begin
			elap_q <= elap_q + CW'(1);
		end
	end

	default clocking cb @(posedge CLK_SYS);
	endclocking
	default disable iff (!RESETN);

	sequence s_first_up_done;
		$past(st_q == tss_pkg::TSS_UP1) && $fell(low_q[0]);
	endsequence

	sequence s_first_dn_done;
		$past(st_q == tss_pkg::TSS_DN1) && $rose(low_q[DN_IDX0]);
	endsequence

	chk_od_drive: assert property (flag_o == 3'h0 && flag_oe == low_q)
		else $error("Flag pins not open-drain");

	chk_off_low: assert property (st_q == tss_pkg::TSS_OFF |-> low_q == 3'h7)
		else $error("Flag released while idle");

	chk_first_delay: assert property (s_first_up_done |-> $past(elap_q) == LEN_UP1 - CW'(1))
		else $error("First release at wrong time");

	chk_up_order: assert property ($fell(low_q[1]) |-> !$past(low_q[0]) && $past(low_q[2]))
		else $error("Rising flag order broken");

	chk_second_delay: assert property ($fell(low_q[1]) |-> $past(elap_q) == LEN_UP2 - CW'(1))
		else $error("Second release at wrong time");

	// Third step has no extra time, so it must match its own length exactly
	chk_third_delay: assert property ($fell(low_q[2]) |-> $past(elap_q) == LEN_UP3 - CW'(1))
		else $error("Third release at wrong time");

	chk_down_first: assert property (s_first_dn_done |-> $past(low_q) == 3'h0
		&& $past(elap_q) == LEN_DN1 - CW'(1))
		else $error("First pull-low wrong");

	// Second pull-low uses its own down timer, never an up length
	chk_down_second: assert property ($past(st_q == tss_pkg::TSS_DN2) && $rose(low_q[DN_IDX1])
		|-> $past(elap_q) == LEN_DN2 - CW'(1))
		else $error("Second pull-low at wrong time");

	chk_glitch_off: assert property (st_q == tss_pkg::TSS_UP1 && en_fall
		|=> st_q == tss_pkg::TSS_OFF ##1 low_q == 3'h7)
		else $error("Early enable drop not rejected");

	chk_up_restart: assert property ((st_q == tss_pkg::TSS_UP2 || st_q == tss_pkg::TSS_UP3) && en_fall && !tmr_done
		|=> elap_q == '0 && $stable(st_q))
		else $error("Power-up timer not restarted");

	chk_settle_up: assert property (st_q == tss_pkg::TSS_SETL_U && tmr_done |-> elap_q == LEN_SETL - CW'(1))
		else $error("Settle pause after power-up wrong");

	chk_dn_restart: assert property ((st_q == tss_pkg::TSS_DN2 || st_q == tss_pkg::TSS_DN3) && en_rise && !tmr_done
		|=> elap_q == '0 && $stable(low_q))
		else $error("Power-down timer not restarted");

	chk_settle_dn: assert property (st_q == tss_pkg::TSS_SETL_D |-> low_q == 3'h7)
		else $error("Flags released during settle");

	chk_sync_lag: assert property (en_rise |-> $past(SEQ_ENABLE, 2))
		else $error("Enable edge without synchronised level");

endmodule

// [verif/tss_regulators.sv]
`timescale 1ns/1ps

// Enable inputs of the three downstream regulators, each behind its own pull-up resistor
module tss_regulators (
	input wire logic [2:0] flag_o,
	input wire logic [2:0] flag_oe,
	output logic [2:0] rail
);
	// A released flag floats up through the resistor, so no stale driven value survives
	assign rail = (flag_oe & flag_o) | ~flag_oe;
endmodule

// [verif/three_rail_supply_sequencer_test.sv]
`timescale 1ns/1ps

module three_rail_supply_sequencer_test;
	// Short step counts keep the run brief; distinct values expose swapped timers
	localparam int UP1 = 20;
	localparam int UP2 = 22;
	localparam int UP3 = 24;
	localparam int DN1 = 26;
	localparam int DN2 = 28;
	localparam int DN3 = 30;
	localparam int EXT = 5;
	localparam int SET = 50;
	// Enable reaches the state two edges late, and the first step starts one edge after that
	localparam int SYNC = 3;

	logic clk_sys = 1'b0;
	logic resetn = 1'b0;
	logic seq_enable = 1'b0;
	wire [2:0] o_pin;
	wire [2:0] oe_pin;
	wire [2:0] rail;
	wire [2:0] o_alt;
	wire [2:0] oe_alt;
	wire [2:0] rail_alt;
	int mismatches = 0;
	int checks_done = 0;

	// 50 MHz system clock
	always #10 clk_sys = ~clk_sys;

	tss_sequencer #(
		.UP_FIRST_CYC(UP1),
		.UP_SECOND_CYC(UP2),
		.UP_THIRD_CYC(UP3),
		.DOWN_FIRST_CYC(DN1),
		.DOWN_SECOND_CYC(DN2),
		.DOWN_THIRD_CYC(DN3),
		.EXTRA_CYC(EXT),
		.SETTLE_CYC(SET)
	) u_dut (
		.CLK_SYS(clk_sys),
		.RESETN(resetn),
		.SEQ_ENABLE(seq_enable),
		.RAIL_FLAG_FIRST_O(o_pin[0]),
		.RAIL_FLAG_FIRST_OE(oe_pin[0]),
		.RAIL_FLAG_SECOND_O(o_pin[1]),
		.RAIL_FLAG_SECOND_OE(oe_pin[1]),
		.RAIL_FLAG_THIRD_O(o_pin[2]),
		.RAIL_FLAG_THIRD_OE(oe_pin[2])
	);

	tss_regulators u_reg (
		.flag_o(o_pin),
		.flag_oe(oe_pin),
		.rail(rail)
	);

	// Build with falling order 2-3-1; same timing keeps it in lock step with u_dut
	tss_sequencer #(
		.UP_FIRST_CYC(UP1),
		.UP_SECOND_CYC(UP2),
		.UP_THIRD_CYC(UP3),
		.DOWN_FIRST_CYC(DN1),
		.DOWN_SECOND_CYC(DN2),
		.DOWN_THIRD_CYC(DN3),
		.EXTRA_CYC(EXT),
		.SETTLE_CYC(SET),
		.DOWN_SEQ(3)
	) u_dut_alt (
		.CLK_SYS(clk_sys),
		.RESETN(resetn),
		.SEQ_ENABLE(seq_enable),
		.RAIL_FLAG_FIRST_O(o_alt[0]),
		.RAIL_FLAG_FIRST_OE(oe_alt[0]),
		.RAIL_FLAG_SECOND_O(o_alt[1]),
		.RAIL_FLAG_SECOND_OE(oe_alt[1]),
		.RAIL_FLAG_THIRD_O(o_alt[2]),
		.RAIL_FLAG_THIRD_OE(oe_alt[2])
	);

	tss_regulators u_reg_alt (
		.flag_o(o_alt),
		.flag_oe(oe_alt),
		.rail(rail_alt)
	);

	task automatic conclude;
		$display("Checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic cmp_vec(input string what, input logic [2:0] exp, input logic [2:0] seen);
		checks_done++;
		if (seen !== exp) begin
			mismatches++;
			$display("ERROR %s expected %b seen %b", what, exp, seen);
		end
	endtask

	task automatic cmp_cnt(input string what, input int lo, input int hi, input int seen);
		checks_done++;
		if (seen < lo || seen > hi) begin
			mismatches++;
			$display("ERROR %s expected %0d..%0d seen %0d", what, lo, hi, seen);
		end
	endtask

	task automatic idle(input int n);
		repeat (n) @(negedge clk_sys);
	endtask

	// Host changes enable away from the sampling edge
	task automatic set_en(input logic v);
		@(negedge clk_sys);
		seq_enable = v;
	endtask

	// Counts cycles until one rail reaches a level, then checks the delay and all three rails
	task automatic step(input string what, input int idx, input logic lvl, input int lo, input int hi,
			input logic [2:0] exp);
		int n;
		n = 0;
		while (rail[idx] !== lvl && n < 2000) begin
			@(negedge clk_sys);
			n++;
		end
		cmp_cnt(what, lo, hi, n);
		cmp_vec(what, exp, rail);
	endtask

	task automatic up_all(input int lo, input int hi);
		step("up first", 0, 1'b1, lo, hi, 3'h1);
		step("up second", 1, 1'b1, UP2, UP2, 3'h3);
		step("up third", 2, 1'b1, UP3, UP3, 3'h7);
	endtask

	task automatic down_all(input int lo, input int hi);
		step("down third", 2, 1'b0, lo, hi, 3'h3);
		cmp_vec("alt down first", 3'h5, rail_alt);
		step("down second", 1, 1'b0, DN2, DN2, 3'h1);
		cmp_vec("alt down second", 3'h1, rail_alt);
		step("down first", 0, 1'b0, DN3, DN3, 3'h0);
		cmp_vec("alt down third", 3'h0, rail_alt);
	endtask

	task automatic sc_reset;
		cmp_vec("after reset", 3'h0, rail);
		cmp_vec("alt after reset", 3'h0, rail_alt);
		idle(20);
		cmp_vec("idle low", 3'h0, rail);
	endtask

	// Exact step lengths from one clock; the first steps carry the extra time
	task automatic sc_full;
		set_en(1'b1);
		up_all(SYNC + UP1 + EXT, SYNC + UP1 + EXT);
		idle(10);
		set_en(1'b0);
		down_all(SYNC + DN1 + EXT, SYNC + DN1 + EXT);
	endtask

	// A short enable pulse must not leave a partly counted first timer behind
	task automatic sc_glitch;
		set_en(1'b1);
		idle(15);
		set_en(1'b0);
		idle(60);
		cmp_vec("glitch", 3'h0, rail);
		set_en(1'b1);
		up_all(SYNC + UP1 + EXT, SYNC + UP1 + EXT);
	endtask

	// Rise during the second pull-low step restarts it, then power-up follows the pause
	task automatic sc_cut_down;
		set_en(1'b0);
		step("cut down third", 2, 1'b0, SYNC + DN1 + EXT, SYNC + DN1 + EXT, 3'h3);
		idle(10);
		set_en(1'b1);
		step("cut down second", 1, 1'b0, SYNC + DN2, SYNC + DN2, 3'h1);
		step("cut down first", 0, 1'b0, DN3, DN3, 3'h0);
		up_all(SET + UP1 + EXT, SET + UP1 + EXT + 4);
	endtask

	// Drop during the second release step restarts it, then power-down follows the pause
	task automatic sc_cut_up;
		set_en(1'b0);
		down_all(SYNC + DN1 + EXT, SYNC + DN1 + EXT);
		set_en(1'b1);
		step("cut up first", 0, 1'b1, SYNC + UP1 + EXT, SYNC + UP1 + EXT, 3'h1);
		idle(10);
		set_en(1'b0);
		step("cut up second", 1, 1'b1, SYNC + UP2, SYNC + UP2, 3'h3);
		step("cut up third", 2, 1'b1, UP3, UP3, 3'h7);
		down_all(SET + DN1 + EXT, SET + DN1 + EXT + 4);
	endtask

	// Main sequence: two cycles of reset, then the scenarios in state order
	initial begin
		idle(2);
		resetn = 1'b1;
		sc_reset();
		sc_full();
		sc_glitch();
		sc_cut_down();
		sc_cut_up();
		conclude();
	end

	// Whole run needs well under two thousand cycles; this cuts a hang short
	initial begin
		repeat (6000) @(posedge clk_sys);
		mismatches++;
		conclude();
	end
endmodule
